// ### src/slm_pkg.sv
// Constants, register map and types for the supply monitor block
// How it works
// - Three-bit threshold select picks eight levels
// - Read-only bit five shows supply low
// - Detector-on bit powers detector up or down
// - Bits seven, six, three read zero
// - Reference enabled automatically with the detector
// - Detector keeps running through power-down modes
// - Flag follows comparator toggles, no hysteresis added
// - Request raised only after the interrupt delay
// - Low supply in power-down sets request, wakes
// - Any request rising edge in power-down wakes, ignoring enables
// - Service clears shared flag; software clears own
package slm_pkg;
    // Clock period in picoseconds, 200 MHz
    localparam int unsigned CLK_PERIOD_PS      = 5000;
    // Interrupt delay after the flag rises, in ns
    localparam int unsigned IRQ_DELAY_NS       = 1000;
    // Detector settling time, in ns
    localparam int unsigned SETTLE_DELAY_NS    = 5000;
    // Least times round up to whole cycles
    localparam int unsigned IRQ_DELAY_CYCLES   = (IRQ_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SETTLE_CYCLES      = (SETTLE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W              = 12;
    localparam logic [CNT_W-1:0] IRQ_DELAY_CNT = CNT_W'(IRQ_DELAY_CYCLES);
    localparam logic [CNT_W-1:0] SETTLE_CNT    = CNT_W'(SETTLE_CYCLES);
    // Register byte addresses
    localparam logic [7:0] CONTROL_ADDR        = 8'h00;
    localparam logic [7:0] STATUS_ADDR         = 8'h04;
    // Control register fields
    localparam int unsigned THRESH_LSB         = 0;
    localparam int unsigned DETECTOR_ON_BIT    = 4;
    localparam int unsigned LOW_FLAG_BIT       = 5;
    // Status register fields
    localparam int unsigned MON_REQ_BIT        = 0;
    localparam int unsigned SHARED_REQ_BIT     = 1;
    localparam int unsigned SETTLED_BIT        = 2;
    // Reset values
    localparam logic [2:0] THRESH_RESET        = 3'h0;
    localparam logic       DETECTOR_ON_RESET   = 1'b0;
    // Bus phase states
    typedef enum logic [1:0] {
        SLM_BUS_IDLE  = 2'b00,
        SLM_BUS_WRITE = 2'b01,
        SLM_BUS_READ  = 2'b10,
        SLM_BUS_RDATA = 2'b11
    } slm_bus_t;
endpackage

// ### src/slm_det_if.sv
// Signals between the register core and the detector front end
`timescale 1ns/1ps
`default_nettype none
interface slm_det_if;
    logic detector_on;     // Software enable
    logic comparator_raw;  // Asynchronous comparator output
    logic low_supply_flag; // Synchronised, gated flag
    logic irq_fire;        // One-cycle pulse when delay expires
    logic settled;         // Settling time has elapsed
    modport front (input detector_on, input comparator_raw,
                   output low_supply_flag, output irq_fire, output settled);
    modport core  (output detector_on, output comparator_raw,
                   input low_supply_flag, input irq_fire, input settled);
endinterface
`default_nettype wire

// ### src/slm_detector.sv
// Comparator synchroniser, interrupt delay and settle timer
`timescale 1ns/1ps
`default_nettype none
module slm_detector (
    input  wire logic hclk,
    input  wire logic hresetn,
    slm_det_if.front  det
);
    import slm_pkg::*;

    logic             sync1;      // First stage, read only by sync2
    logic             sync2;      // Second stage
    logic             flag;       // Low-supply flag
    logic [CNT_W-1:0] dly_cnt;    // Interrupt delay counter
    logic             fire;       // Delay expiry pulse
    logic [CNT_W-1:0] settle_cnt; // Settle timer
    logic             next_flag;
    logic [CNT_W-1:0] next_dly_cnt;
    logic             next_fire;
    logic [CNT_W-1:0] next_settle_cnt;

    // Next values: flag tracks comparator with no filtering, so slow
    // supplies near the trip point toggle it freely
    always_comb begin
        next_flag       = det.detector_on & sync2;
        next_dly_cnt    = dly_cnt;
        next_fire       = 1'b0;
        next_settle_cnt = settle_cnt;
        if (!det.detector_on || !flag) begin
            next_dly_cnt = '0;
        end else if (dly_cnt != IRQ_DELAY_CNT) begin
            next_dly_cnt = dly_cnt + CNT_W'(1);
            next_fire    = (dly_cnt == IRQ_DELAY_CNT - CNT_W'(1));
        end
        if (!det.detector_on) begin
            next_settle_cnt = '0;
        end else if (settle_cnt != SETTLE_CNT) begin
            next_settle_cnt = settle_cnt + CNT_W'(1);
        end
    end

    // Registers, synchroniser included
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1      <= 1'b0;
            sync2      <= 1'b0;
            flag       <= 1'b0;
            dly_cnt    <= '0;
            fire       <= 1'b0;
            settle_cnt <= '0;
        end else begin
            sync1      <= det.comparator_raw;
            sync2      <= sync1;
            flag       <= next_flag;
            dly_cnt    <= next_dly_cnt;
            fire       <= next_fire;
            settle_cnt <= next_settle_cnt;
        end
    end

    assign det.low_supply_flag = flag;
    assign det.irq_fire        = fire;
    assign det.settled         = (settle_cnt == SETTLE_CNT);

    // Flag rises only one cycle after synchronised comparator is high
    a_flag_sync: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(flag) |-> $past(sync2) && $past(det.detector_on))
        else $error("flag rose without synchronised comparator");
    // Fire needs the flag high for the whole delay
    a_fire_delay: assert property (@(posedge hclk) disable iff (!hresetn)
        fire |-> dly_cnt == IRQ_DELAY_CNT && $past(flag))
        else $error("interrupt fired before the delay");
    // Counter held at zero while off
    a_off_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        !det.detector_on |=> dly_cnt == '0 && !flag)
        else $error("counter or flag not cleared while off");
endmodule
`default_nettype wire

// ### src/slm_top.sv
// Supply monitor: AHB-Lite registers, request flags and wake-up
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module slm_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        comparator_low,
    input  wire logic        power_down,
    input  wire logic        irq_service,
    output logic             detector_power,
    output logic             reference_enable,
    output logic      [2:0]  threshold_select,
    output logic             monitor_irq_request,
    output logic             shared_irq_request,
    output logic             wake_request
);
    import slm_pkg::*;

    slm_det_if det ();

    slm_bus_t   state;          // Bus phase
    logic [7:0] addr_q;         // Latched address
    logic       detector_on;    // Control bit
    logic [2:0] thresh;         // Threshold code
    logic       mon_req;        // Monitor request, software cleared
    logic       shared_req;     // Shared request, cleared by service
    logic       wake;           // Wake pulse
    logic [31:0] rdata;         // Read data register
    slm_bus_t   next_state;
    logic [7:0] next_addr_q;
    logic       next_detector_on;
    logic [2:0] next_thresh;
    logic       next_mon_req;
    logic       next_shared_req;
    logic       next_wake;
    logic [31:0] next_rdata;
    logic       accept;         // Address phase taken
    logic [31:0] read_mux;      // Register read value
    logic       mon_clear;      // Software clear of monitor request
    logic       mon_rise;       // Monitor request set edge
    logic       shared_rise;    // Shared request set edge

    // Detector front end
    slm_detector u_det (
        .hclk    (hclk),
        .hresetn (hresetn),
        .det     (det)
    );

    assign det.detector_on    = detector_on;
    assign det.comparator_raw = comparator_low;

    // Outputs; analog parts follow the enable even in power-down
    assign detector_power      = detector_on;
    assign reference_enable    = detector_on;
    assign threshold_select    = thresh;
    assign monitor_irq_request = mon_req;
    assign shared_irq_request  = shared_req;
    assign wake_request        = wake;
    assign hrdata              = rdata;
    assign hresp               = 1'b0;
    // One wait state on reads so a read right after a write sees it
    assign hreadyout           = (state != SLM_BUS_READ);

    // Read value, unused bits zero
    always_comb begin
        read_mux = 32'h0;
        if (addr_q == CONTROL_ADDR) begin
            read_mux[THRESH_LSB +: 3]    = thresh;
            read_mux[DETECTOR_ON_BIT]    = detector_on;
            read_mux[LOW_FLAG_BIT]       = det.low_supply_flag;
        end else if (addr_q == STATUS_ADDR) begin
            read_mux[MON_REQ_BIT]        = mon_req;
            read_mux[SHARED_REQ_BIT]     = shared_req;
            read_mux[SETTLED_BIT]        = det.settled;
        end
    end

    // Bus phase and register next values
    always_comb begin
        accept           = hsel && htrans[1] && hready;
        next_state       = state;
        next_addr_q      = addr_q;
        next_detector_on = detector_on;
        next_thresh      = thresh;
        next_rdata       = rdata;
        mon_clear        = 1'b0;
        case (state)
            SLM_BUS_WRITE: begin
                // Write data phase
                if (addr_q == CONTROL_ADDR) begin
                    next_detector_on = hwdata[DETECTOR_ON_BIT];
                    next_thresh      = hwdata[THRESH_LSB +: 3];
                end else if (addr_q == STATUS_ADDR) begin
                    mon_clear        = hwdata[MON_REQ_BIT];
                end
            end
            SLM_BUS_READ: begin
                // Wait state loads read data
                next_rdata = read_mux;
            end
            SLM_BUS_IDLE, SLM_BUS_RDATA: begin
                // Nothing pending
            end
            default: begin
                next_state = SLM_BUS_IDLE;
            end
        endcase
        if (state != SLM_BUS_READ) begin
            if (accept) begin
                next_addr_q = haddr;
                next_state  = hwrite ? SLM_BUS_WRITE : SLM_BUS_READ;
            end else begin
                next_state  = SLM_BUS_IDLE;
            end
        end else begin
            next_state = SLM_BUS_RDATA;
        end
        // Set wins over clear on the monitor request
        mon_rise        = det.irq_fire && !mon_req;
        next_mon_req    = det.irq_fire || (mon_req && !mon_clear);
        shared_rise     = mon_rise && !shared_req;
        next_shared_req = mon_rise || (shared_req && !irq_service);
        // A flag already high cannot wake; enables play no part
        next_wake       = power_down && (mon_rise || shared_rise);
    end

    // State registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state       <= SLM_BUS_IDLE;
            addr_q      <= 8'h00;
            detector_on <= DETECTOR_ON_RESET;
            thresh      <= THRESH_RESET;
            mon_req     <= 1'b0;
            shared_req  <= 1'b0;
            wake        <= 1'b0;
            rdata       <= 32'h0;
        end else begin
            state       <= next_state;
            addr_q      <= next_addr_q;
            detector_on <= next_detector_on;
            thresh      <= next_thresh;
            mon_req     <= next_mon_req;
            shared_req  <= next_shared_req;
            wake        <= next_wake;
            rdata       <= next_rdata;
        end
    end

    // Checks on what software and the interrupt side see

    // Unused control bits read as zero
    a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        state == SLM_BUS_RDATA && addr_q == CONTROL_ADDR |-> hrdata[7:6] == 2'b00 && hrdata[3] == 1'b0)
        else $error("reserved control bits read nonzero");
    // Upper bytes of the control word read as zero too
    a_ctrl_upper: assert property (@(posedge hclk) disable iff (!hresetn)
        state == SLM_BUS_RDATA && addr_q == CONTROL_ADDR |-> hrdata[31:8] == 24'h0)
        else $error("upper control bits read nonzero");
    // Control write lands on the next edge
    a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
        state == SLM_BUS_WRITE && addr_q == CONTROL_ADDR
        |=> threshold_select == $past(hwdata[2:0]) && detector_power == $past(hwdata[4]))
        else $error("control write not applied");
    // Threshold moves only through a control write
    a_thresh_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !(state == SLM_BUS_WRITE && addr_q == CONTROL_ADDR) |=> $stable(threshold_select))
        else $error("threshold changed without a write");
    // Read data carries the flag seen in the wait state
    a_flag_read: assert property (@(posedge hclk) disable iff (!hresetn)
        state == SLM_BUS_READ && addr_q == CONTROL_ADDR |=> hrdata[5] == $past(det.low_supply_flag))
        else $error("flag read mismatch");
    // Delay expiry always raises the monitor request
    a_req_set: assert property (@(posedge hclk) disable iff (!hresetn)
        det.irq_fire |=> monitor_irq_request)
        else $error("request not set by delay expiry");
    // Request stays until software clears it
    a_req_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        monitor_irq_request && !det.irq_fire && !mon_clear |=> monitor_irq_request)
        else $error("request lost without software clear");
    // Software clear lowers the request when no new fire
    a_sw_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        state == SLM_BUS_WRITE && addr_q == STATUS_ADDR && hwdata[MON_REQ_BIT] && !det.irq_fire
        |=> !monitor_irq_request)
        else $error("software clear of request ignored");
    // Servicing the shared flag leaves the monitor request alone
    a_service_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_service && monitor_irq_request && !mon_clear |=> monitor_irq_request)
        else $error("service cleared the monitor request");
    // Service clears the shared flag unless a new rise wins
    a_shared_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_service && !mon_rise |=> !shared_irq_request)
        else $error("service did not clear shared flag");
    // Wake needs power-down and a fresh request
    a_wake_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        wake_request |-> $past(power_down) && $rose(monitor_irq_request))
        else $error("wake without rising request");
    // A fresh request in power-down wakes on the next edge
    a_wake_fresh: assert property (@(posedge hclk) disable iff (!hresetn)
        power_down && det.irq_fire && !monitor_irq_request |=> wake_request)
        else $error("fresh request in power-down gave no wake");
    // A request already high can never wake the chip
    a_wake_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
        monitor_irq_request |=> !wake_request)
        else $error("wake from a request already high");
    // Reference enable is the detector enable, nothing else
    a_ref_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        reference_enable == detector_power && detector_power == detector_on)
        else $error("reference not tied to detector enable");
    // Reference follows the written enable bit with no extra control
    a_ref_write: assert property (@(posedge hclk) disable iff (!hresetn)
        state == SLM_BUS_WRITE && addr_q == CONTROL_ADDR |=> reference_enable == $past(hwdata[DETECTOR_ON_BIT]))
        else $error("reference did not follow the written enable");
endmodule
`default_nettype wire

// ### verification/slm_supply_model.sv
// Far-side model: analog supply comparator and shared interrupt controller
`timescale 1ns/1ps
`default_nettype none
module slm_supply_model (
    input  wire logic        hclk,
    input  wire logic [12:0] supply_mv,
    input  wire logic [2:0]  threshold_select,
    input  wire logic        detector_power,
    input  wire logic        reference_enable,
    input  wire logic        shared_irq_request,
    input  wire logic        service_en,
    output logic             comparator_low,
    output logic             irq_service
);
    // Trip levels in millivolts, code zero lowest
    localparam logic [12:0] TRIP [8] = '{13'd2000, 13'd2200, 13'd2400, 13'd2700,
                                         13'd3000, 13'd3300, 13'd3600, 13'd4400};
    initial begin
        comparator_low = 1'b0;
        irq_service    = 1'b0;
    end
    // Comparator; unpowered it gives garbage, so the design must not trust it
    always @(posedge hclk) begin
        if (detector_power && reference_enable) begin
            comparator_low <= (supply_mv < TRIP[threshold_select]);
        end else begin
            comparator_low <= ~comparator_low;
        end
        // Service pulse while the shared flag is up, only when allowed
        irq_service <= service_en && shared_irq_request && !irq_service;
    end
endmodule
`default_nettype wire

// ### verification/supply_low_voltage_monitor_tb.sv
// Self-checking bench for the supply monitor block
`timescale 1ns/1ps
`default_nettype none
module supply_low_voltage_monitor_tb;
    import slm_pkg::*;
    localparam logic [12:0] TRIP [8] = '{13'd2000, 13'd2200, 13'd2400, 13'd2700,
                                         13'd3000, 13'd3300, 13'd3600, 13'd4400};
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;  // Bus control
    logic [7:0]  haddr;                                          // Byte address
    logic [1:0]  htrans;                                         // Transfer kind
    logic [2:0]  hsize;                                          // Always a word
    logic [31:0] hwdata, hrdata, rd;                             // Bus data
    logic        comparator_low, power_down, irq_service, service_en;
    logic        detector_power, reference_enable, monitor_irq_request;
    logic        shared_irq_request, wake_request;
    logic [2:0]  threshold_select;
    logic [12:0] supply_mv;                                      // Supply seen by the model
    int          fail_count, check_count, wake_count, base;
    slm_top u_slm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .comparator_low(comparator_low), .power_down(power_down),
        .irq_service(irq_service), .detector_power(detector_power), .reference_enable(reference_enable),
        .threshold_select(threshold_select), .monitor_irq_request(monitor_irq_request),
        .shared_irq_request(shared_irq_request), .wake_request(wake_request));
    slm_supply_model u_slm_supply_model (.hclk(hclk), .supply_mv(supply_mv),
        .threshold_select(threshold_select), .detector_power(detector_power),
        .reference_enable(reference_enable), .shared_irq_request(shared_irq_request),
        .service_en(service_en), .comparator_low(comparator_low), .irq_service(irq_service));
    // 200 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // Wake pulses last one cycle, so count them at every edge
    always @(posedge hclk) begin
        if (wake_request === 1'b1) begin
            wake_count <= wake_count + 1;
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One single transfer; waits are ended only by the watchdog
    task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", 32'(hresp), 32'h0);
    endtask
    task automatic reg_check(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb_xfer(a, 1'b0, 32'h0);
        check(n, rd & m, e);
    endtask
    task automatic test_regs();
        check("outputs", 32'({detector_power, reference_enable, monitor_irq_request, wake_request}), 0);
        reg_check("ctrl reset", CONTROL_ADDR, 32'hffffffff, 32'h0);
        ahb_xfer(CONTROL_ADDR, 1'b1, 32'hffffffff);
        // Flag not trusted until the settle time has passed
        reg_check("ctrl rw", CONTROL_ADDR, 32'hffffffdf, 32'h17);
        check("power", 32'({detector_power, reference_enable}), 32'h3);
        ahb_xfer(8'h08, 1'b1, 32'hffffffff);
        reg_check("unmapped", 8'h08, 32'hffffffff, 32'h0);
        // Software waits out the settle time before trusting the flag
        repeat (SETTLE_CYCLES) @(posedge hclk);
        reg_check("settled", STATUS_ADDR, 32'h4, 32'h4);
        reg_check("ctrl settled", CONTROL_ADDR, 32'hffffffff, 32'h17);
        $display("test regs done");
    endtask
    // Every code, with the supply hovering either side of its level
    task automatic test_thresholds();
        for (int c = 0; c < 8; c++) begin
            ahb_xfer(CONTROL_ADDR, 1'b1, 32'h10 | c);
            @(posedge hclk);
            check("threshold", 32'(threshold_select), c);
            supply_mv <= TRIP[c] - 13'd20;
            repeat (6) @(posedge hclk);
            reg_check("flag low", CONTROL_ADDR, 32'h20, 32'h20);
            supply_mv <= TRIP[c] + 13'd20;
            repeat (6) @(posedge hclk);
            reg_check("flag clear", CONTROL_ADDR, 32'h20, 32'h0);
        end
        supply_mv <= 13'd5000;
        $display("test thresholds done");
    endtask
    task automatic test_irq_delay();
        // Let the previous supply value take effect first
        @(posedge hclk);
        supply_mv <= 13'd1000;
        repeat (IRQ_DELAY_CYCLES) @(posedge hclk);
        check("req early", 32'(monitor_irq_request), 32'h0);
        repeat (10) @(posedge hclk);
        check("req set", 32'(monitor_irq_request), 32'h1);
        check("shared set", 32'(shared_irq_request), 32'h1);
        service_en <= 1'b1;
        repeat (4) @(posedge hclk);
        check("shared served", 32'(shared_irq_request), 32'h0);
        reg_check("req kept", STATUS_ADDR, 32'h3, 32'h1);
        supply_mv <= 13'd5000;
        repeat (6) @(posedge hclk);
        ahb_xfer(STATUS_ADDR, 1'b1, 32'h1);
        @(posedge hclk);
        check("req cleared", 32'(monitor_irq_request), 32'h0);
        $display("test irq delay done");
    endtask
    // A fresh request wakes once; a request left high cannot wake again
    task automatic test_wake();
        base = wake_count;
        power_down <= 1'b1;
        supply_mv <= 13'd1000;
        repeat (IRQ_DELAY_CYCLES + 10) @(posedge hclk);
        check("wake once", 32'(wake_count - base), 32'h1);
        supply_mv <= 13'd5000;
        repeat (10) @(posedge hclk);
        supply_mv <= 13'd1000;
        repeat (IRQ_DELAY_CYCLES + 10) @(posedge hclk);
        check("no rewake", 32'(wake_count - base), 32'h1);
        supply_mv <= 13'd5000;
        power_down <= 1'b0;
        repeat (6) @(posedge hclk);
        ahb_xfer(STATUS_ADDR, 1'b1, 32'h1);
        $display("test wake done");
    endtask
    // Off detector: garbage comparator must not reach flag or request
    task automatic test_off();
        ahb_xfer(CONTROL_ADDR, 1'b1, 32'h07);
        supply_mv <= 13'd1000;
        repeat (IRQ_DELAY_CYCLES + 10) @(posedge hclk);
        check("power off", 32'({detector_power, reference_enable}), 32'h0);
        reg_check("flag off", CONTROL_ADDR, 32'hff, 32'h07);
        check("no req", 32'(monitor_irq_request), 32'h0);
        $display("test off done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        finish_test();
    end
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, power_down, service_en} = '0;
        {fail_count, check_count, wake_count, base} = '0;
        hsize = 3'h2;
        supply_mv = 13'd5000;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_regs();
        test_thresholds();
        test_irq_delay();
        test_wake();
        test_off();
        finish_test();
    end
endmodule
`default_nettype wire
